// >>> core/ssrc_pkg.sv
// Package for the synchronous serial receive controller.
// Assumes a single 100 MHz system clock and an AHB-Lite register port.
package ssrc_pkg;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CLKDIV = 8'h04;
  localparam logic [7:0] OFF_RXCLK = 8'h10;
  localparam logic [7:0] OFF_RXFRM = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h40;
  localparam logic [7:0] OFF_RXDATA = 8'h20;
  localparam logic [7:0] OFF_RXSYNC = 8'h30;
  localparam logic [7:0] OFF_CMP0 = 8'h38;
  localparam logic [7:0] OFF_CMP1 = 8'h3c;
  localparam logic [7:0] OFF_TXCLK = 8'h18;
  // Command bits
  localparam int CMD_RX_ON = 0;
  localparam int CMD_RX_OFF = 1;
  localparam int CMD_TX_ON = 8;
  localparam int CMD_TX_OFF = 9;
  localparam int CMD_SOFT_RST = 15;
  // Receive clocking fields
  localparam int RC_CKS = 0;
  localparam int RC_CKO = 2;
  localparam int RC_CKI = 5;
  localparam int RC_CKG = 6;
  localparam int RC_START = 8;
  localparam int RC_STOP = 12;
  localparam int RC_DLY = 16;
  localparam int RC_PER = 24;
  // Receive framing fields
  localparam int RF_LEN = 0;
  localparam int RF_LOOP = 5;
  localparam int RF_HIGH_BIT_FIRST = 7;
  localparam int RF_NB = 8;
  localparam int RF_SYNC_LENGTH = 16;
  localparam int RF_SYNC_OUTPUT_SHAPE = 20;
  localparam int RF_EDGE = 24;
  // Status bits
  localparam int ST_RXRDY = 1;
  localparam int ST_RX_SYNC_EDGE_FLAG = 11;
  localparam int ST_TRANSMIT_ON_CMD = 16;
  localparam int ST_RECEIVE_ON_CMD = 17;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  localparam logic [11:0] DIV_MAX = 12'hfff;
  localparam logic [31:0] CMP_MASK_MAX = 32'h0000_ffff;
  typedef enum logic [1:0] {SSRC_IDLE, SSRC_DELAY, SSRC_SYNC, SSRC_DATA} ssrc_phase_type;
endpackage

// >>> core/ssrc_top.sv
// Receive clocking, framing and command logic of a synchronous serial port.
// Assumes AHB-Lite single word transfers and pins synchronous to clk_sys.
// Summary of operation
// - Enable command turns direction on unless its disable bit is set too.
// - Disable command turns transmit off at once, receive off after the current word completes.
// - Software reset command beats every other bit in the same write.
// - Divider zero stops; else bit clock equals clock over twice divider.
// - Receive clock source: divided, transmit clock, or receive clock pin.
// - Receive clock pin: input, continuous output, or output during transfer.
// - Inversion swaps sampling and sync-drive edges; pin clock never inverted.
// - Gating: none, only while sync pin low, or only while high.
// - Start mode zero begins on enable and restarts after each transfer.
// - Start codes: transmit start, levels, edges, any change, compare zero.
// - Compare start: stop bit clear waits again, set runs until compare one.
// - Nonzero start delay inserts that many bit clocks before first bit.
// - Nonzero period makes sync pulse every two times period plus two clocks.
// - Words hold length plus one bits; length zero never programmed.
// - DMA size: byte up to 7, half-word to 15, word above.
// - High-bit-first places first sampled bit at the top of the word.
// - Each start receives word count plus one words.
// - Sync length sets sync bits sampled and compare width.
// - Generated sync pulse lasts sync length plus one bit clocks.
// - Sync output shape: input, pulses, levels during transfer, or toggle.
// - Sync edge flag follows rising or falling edge per edge select.
// - Compare zero checks latest bits every sample, at most sixteen wide.
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ssrc_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_clock_pin_i,
  output logic rx_clock_pin_o,
  output logic rx_clock_pin_oe,
  input wire logic rx_sync_pin_i,
  output logic rx_sync_pin_o,
  output logic rx_sync_pin_oe,
  input wire logic rx_data_pin,
  input wire logic tx_clock_pin,
  input wire logic tx_sync_pin,
  input wire logic tx_data_pin,
  input wire logic tx_start,
  output logic tx_enabled,
  output logic [1:0] dma_size,
  output logic rx_word_valid
);
  typedef struct packed {
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [11:0] div;
    logic [31:0] rcm;
    logic [31:0] rfm;
    logic [31:0] cmp0;
    logic [31:0] cmp1;
    logic rx_en;
    logic rx_off_pend;
    logic tx_en;
    logic [11:0] div_cnt;
    logic div_clk;
    logic rclk_prev;
    logic rf_prev;
    logic rf_smp;
    logic rf_live;
    logic fs_prev;
    logic [7:0] dly_cnt;
    logic [5:0] bit_cnt;
    logic [3:0] word_cnt;
    logic [31:0] shift;
    logic [31:0] data;
    logic [15:0] sync;
    logic [15:0] hist;
    logic [8:0] per_cnt;
    logic [4:0] fs_cnt;
    logic fs_out;
    logic fs_tog;
    logic armed;
    logic valid;
    logic rxrdy;
    logic syn_flag;
    ssrc_pkg::ssrc_phase_type phase;
  } ssrc_state_type;

  ssrc_state_type s_q, s_d;

  logic acc_ok, wr_cmd, soft_rst;
  logic [31:0] wr_val;
  logic [1:0] rx_clock_source, rx_clock_output_mode, rx_clock_gating;
  logic rx_clock_invert, stop_b, loop_b, high_bit_first, edge_sel;
  logic [3:0] start_sel, dnb, sync_length;
  logic [4:0] dlen;
  logic [2:0] sync_output_shape;
  logic [7:0] start_delay;
  logic [7:0] period;
  logic rclk_src, rf_in, rd_in, rclk_gated, smp_edge, drv_edge;
  logic start_evt, cmp0_hit, cmp1_hit, in_xfer;
  logic [15:0] cmp_mask;

  assign rx_clock_source = s_q.rcm[ssrc_pkg::RC_CKS +: 2];
  assign rx_clock_output_mode = s_q.rcm[ssrc_pkg::RC_CKO +: 2];
  assign rx_clock_invert = s_q.rcm[ssrc_pkg::RC_CKI];
  assign rx_clock_gating = s_q.rcm[ssrc_pkg::RC_CKG +: 2];
  assign start_sel = s_q.rcm[ssrc_pkg::RC_START +: 4];
  assign stop_b = s_q.rcm[ssrc_pkg::RC_STOP];
  assign start_delay = s_q.rcm[ssrc_pkg::RC_DLY +: 8];
  assign period = s_q.rcm[ssrc_pkg::RC_PER +: 8];
  assign dlen = s_q.rfm[ssrc_pkg::RF_LEN +: 5];
  assign loop_b = s_q.rfm[ssrc_pkg::RF_LOOP];
  assign high_bit_first = s_q.rfm[ssrc_pkg::RF_HIGH_BIT_FIRST];
  assign dnb = s_q.rfm[ssrc_pkg::RF_NB +: 4];
  assign sync_length = s_q.rfm[ssrc_pkg::RF_SYNC_LENGTH +: 4];
  assign sync_output_shape = s_q.rfm[ssrc_pkg::RF_SYNC_OUTPUT_SHAPE +: 3];
  assign edge_sel = s_q.rfm[ssrc_pkg::RF_EDGE];

  assign acc_ok = hsel && hready && htrans[1];
  assign wr_val = hwdata;
  assign wr_cmd = s_q.wr_pend && s_q.addr == ssrc_pkg::OFF_CMD;
  assign soft_rst = wr_cmd && wr_val[ssrc_pkg::CMD_SOFT_RST];
  assign in_xfer = s_q.phase != ssrc_pkg::SSRC_IDLE;

  // Source, loop-back and gating of the receive clock
  always_comb begin
    case (rx_clock_source)
      2'h0: rclk_src = s_q.div_clk;
      2'h1: rclk_src = tx_clock_pin;
      2'h2: rclk_src = rx_clock_pin_i;
      default: rclk_src = 1'b0;
    endcase
    if (loop_b) begin
      rclk_src = tx_clock_pin;
    end
    rf_in = loop_b ? tx_sync_pin : rx_sync_pin_i;
    rd_in = loop_b ? tx_data_pin : rx_data_pin;
    case (rx_clock_gating)
      2'h1: rclk_gated = rclk_src && !rf_in;
      2'h2: rclk_gated = rclk_src && rf_in;
      default: rclk_gated = rclk_src;
    endcase
  end

  // Sample on falling edge unless inverted; drive sync on the other edge
  assign smp_edge = rx_clock_invert ? (rclk_gated && !s_q.rclk_prev) : (!rclk_gated && s_q.rclk_prev);
  assign drv_edge = rx_clock_invert ? (!rclk_gated && s_q.rclk_prev) : (rclk_gated && !s_q.rclk_prev);

  assign cmp_mask = (sync_length == 4'hf) ? 16'hffff : ((16'h1 << (sync_length + 4'h1)) - 16'h1);
  assign cmp0_hit = ((s_q.hist ^ s_q.cmp0[15:0]) & cmp_mask) == 16'h0;
  assign cmp1_hit = ((s_q.hist ^ s_q.cmp1[15:0]) & cmp_mask) == 16'h0;

  always_comb begin
    case (start_sel)
      4'h0: start_evt = 1'b1;
      4'h1: start_evt = tx_start;
      4'h2: start_evt = !rf_in;
      4'h3: start_evt = rf_in;
      4'h4: start_evt = !rf_in && s_q.rf_smp;
      4'h5: start_evt = rf_in && !s_q.rf_smp;
      4'h6, 4'h7: start_evt = rf_in != s_q.rf_smp;
      4'h8: start_evt = cmp0_hit || s_q.armed;
      default: start_evt = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.rclk_prev = rclk_gated;
    s_d.rf_prev = rf_in;
    s_d.rf_live = 1'b1;
    // Bus address phase capture
    s_d.wr_pend = acc_ok && hwrite;
    s_d.rd_pend = acc_ok && !hwrite;
    if (acc_ok) begin
      s_d.addr = haddr;
    end
    if (acc_ok && !hwrite) begin
      case (haddr)
        ssrc_pkg::OFF_CLKDIV: s_d.rdata = {20'h0, s_q.div};
        ssrc_pkg::OFF_RXCLK: s_d.rdata = s_q.rcm;
        ssrc_pkg::OFF_RXFRM: s_d.rdata = s_q.rfm;
        ssrc_pkg::OFF_RXDATA: s_d.rdata = s_q.data;
        ssrc_pkg::OFF_RXSYNC: s_d.rdata = {16'h0, s_q.sync};
        ssrc_pkg::OFF_CMP0: s_d.rdata = s_q.cmp0;
        ssrc_pkg::OFF_CMP1: s_d.rdata = s_q.cmp1;
        ssrc_pkg::OFF_STAT: s_d.rdata = ({31'h0, s_q.rxrdy} << ssrc_pkg::ST_RXRDY)
          | ({31'h0, s_q.syn_flag} << ssrc_pkg::ST_RX_SYNC_EDGE_FLAG)
          | ({31'h0, s_q.tx_en} << ssrc_pkg::ST_TRANSMIT_ON_CMD)
          | ({31'h0, s_q.rx_en} << ssrc_pkg::ST_RECEIVE_ON_CMD);
        default: s_d.rdata = 32'h0;
      endcase
    end
    if (s_q.rd_pend && s_q.addr == ssrc_pkg::OFF_RXDATA) begin
      s_d.rxrdy = 1'b0;
    end
    if (s_q.rd_pend && s_q.addr == ssrc_pkg::OFF_STAT) begin
      s_d.syn_flag = 1'b0;
    end
    if (s_q.wr_pend) begin
      case (s_q.addr)
        ssrc_pkg::OFF_CLKDIV: s_d.div = wr_val[11:0];
        ssrc_pkg::OFF_RXCLK: s_d.rcm = wr_val;
        ssrc_pkg::OFF_RXFRM: s_d.rfm = wr_val;
        ssrc_pkg::OFF_CMP0: begin
          s_d.cmp0 = wr_val;
          s_d.armed = 1'b0;
        end
        ssrc_pkg::OFF_CMP1: s_d.cmp1 = wr_val;
        default: s_d = s_d;
      endcase
    end
    if (wr_cmd) begin
      if (wr_val[ssrc_pkg::CMD_TX_OFF]) begin
        s_d.tx_en = 1'b0;
      end else if (wr_val[ssrc_pkg::CMD_TX_ON]) begin
        s_d.tx_en = 1'b1;
      end
      if (wr_val[ssrc_pkg::CMD_RX_OFF]) begin
        s_d.rx_off_pend = 1'b1;
      end else if (wr_val[ssrc_pkg::CMD_RX_ON]) begin
        s_d.rx_en = 1'b1;
        s_d.rx_off_pend = 1'b0;
      end
    end
    // Bit clock divider
    if (s_q.div == 12'h0) begin
      s_d.div_cnt = 12'h0;
      s_d.div_clk = 1'b0;
    end else if (s_q.div_cnt >= s_q.div - 12'h1) begin
      s_d.div_cnt = 12'h0;
      s_d.div_clk = !s_q.div_clk;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 12'h1;
    end
    if (s_q.rx_off_pend && s_q.phase != ssrc_pkg::SSRC_DATA) begin
      s_d.rx_en = 1'b0;
      s_d.rx_off_pend = 1'b0;
    end
    // Sync edge flag; a new edge wins over the read clear
    if (s_q.rf_live
        && (edge_sel ? (s_q.rf_prev && !rf_in) : (!s_q.rf_prev && rf_in))) begin
      s_d.syn_flag = 1'b1;
    end
    if (smp_edge) begin
      s_d.hist = {s_q.hist[14:0], rd_in};
      s_d.rf_smp = rf_in;
    end
    if (drv_edge) begin
      if (period != 8'h0) begin
        if ({1'b0, s_q.per_cnt} >= {period, 1'b1}) begin
          s_d.per_cnt = 9'h0;
          s_d.fs_cnt = 5'({1'b0, sync_length} + 5'h1);
          s_d.fs_tog = !s_q.fs_tog;
        end else begin
          s_d.per_cnt = s_q.per_cnt + 9'h1;
        end
      end else begin
        s_d.per_cnt = 9'h0;
      end
      if (s_q.fs_cnt != 5'h0 && !(period != 8'h0 && s_d.per_cnt == 9'h0)) begin
        s_d.fs_cnt = s_q.fs_cnt - 5'h1;
      end
    end
    case (sync_output_shape)
      3'h1: s_d.fs_out = !(s_d.fs_cnt != 5'h0);
      3'h2: s_d.fs_out = s_d.fs_cnt != 5'h0;
      3'h3: s_d.fs_out = !in_xfer;
      3'h4: s_d.fs_out = in_xfer;
      3'h5: s_d.fs_out = s_d.fs_tog;
      default: s_d.fs_out = 1'b0;
    endcase
    case (s_q.phase)
      ssrc_pkg::SSRC_IDLE: begin
        if (s_q.rx_en && !s_q.rx_off_pend && start_evt && smp_edge) begin
          if (start_sel == 4'h8) begin
            s_d.armed = stop_b;
          end
          s_d.word_cnt = 4'h0;
          s_d.bit_cnt = (start_delay == 8'h1) ? 6'h0 : 6'h1;
          s_d.dly_cnt = start_delay - 8'h1;
          s_d.sync = {15'h0, rd_in};
          s_d.phase = (start_delay > 8'h1) ? ssrc_pkg::SSRC_DELAY : ssrc_pkg::SSRC_DATA;
          if (start_delay == 8'h0) begin
            s_d.sync = 16'h0;
            s_d.shift = high_bit_first ? {s_q.shift[30:0], rd_in} : {rd_in, s_q.shift[31:1]};
          end
        end
      end
      ssrc_pkg::SSRC_DELAY: begin
        if (smp_edge) begin
          if (s_q.bit_cnt <= {2'h0, sync_length}) begin
            s_d.sync = {s_q.sync[14:0], rd_in};
            s_d.bit_cnt = s_q.bit_cnt + 6'h1;
          end
          s_d.dly_cnt = s_q.dly_cnt - 8'h1;
          if (s_q.dly_cnt == 8'h1) begin
            s_d.bit_cnt = 6'h0;
            s_d.phase = ssrc_pkg::SSRC_DATA;
          end
        end
      end
      ssrc_pkg::SSRC_DATA: begin
        if (smp_edge) begin
          if (high_bit_first) begin
            s_d.shift = {s_q.shift[30:0], rd_in};
          end else begin
            s_d.shift = {rd_in, s_q.shift[31:1]};
          end
          s_d.bit_cnt = s_q.bit_cnt + 6'h1;
          if (s_q.bit_cnt == {1'b0, dlen}) begin
            s_d.bit_cnt = 6'h0;
            s_d.data = high_bit_first ? s_d.shift : (s_d.shift >> (5'd31 - dlen));
            s_d.valid = 1'b1;
            s_d.rxrdy = 1'b1;
            s_d.word_cnt = s_q.word_cnt + 4'h1;
            if (s_q.word_cnt == dnb || s_q.rx_off_pend) begin
              s_d.phase = ssrc_pkg::SSRC_IDLE;
              if (start_sel == 4'h8 && stop_b && cmp1_hit) begin
                s_d.armed = 1'b0;
              end
            end
          end
        end
      end
      default: s_d.phase = ssrc_pkg::SSRC_IDLE;
    endcase
    if (start_sel == 4'h8 && stop_b && cmp1_hit && smp_edge) begin
      s_d.armed = 1'b0;
    end
    if (soft_rst) begin
      s_d = '0;
      s_d.phase = ssrc_pkg::SSRC_IDLE;
      s_d.rclk_prev = rclk_gated;
      s_d.rf_prev = rf_in;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign tx_enabled = s_q.tx_en;
  assign rx_word_valid = s_q.valid;
  assign dma_size = (dlen <= 5'd7) ? 2'h0 : ((dlen <= 5'd15) ? 2'h1 : 2'h2);
  // Output clock is the ungated-by-inversion source
  assign rx_clock_pin_o = (rx_clock_output_mode == 2'h1) ? rclk_src : (rclk_src && in_xfer);
  assign rx_clock_pin_oe = (rx_clock_output_mode == 2'h1) || (rx_clock_output_mode == 2'h2);
  assign rx_sync_pin_o = s_q.fs_out;
  assign rx_sync_pin_oe = (sync_output_shape != 3'h0) && (sync_output_shape <= 3'h5);

  soft_reset_cmd_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    soft_rst |=> (!s_q.rx_en && !s_q.tx_en && s_q.phase == ssrc_pkg::SSRC_IDLE))
    else $error("Software reset did not clear state");
  enable_cmd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_cmd && !soft_rst && wr_val[ssrc_pkg::CMD_TX_ON] && !wr_val[ssrc_pkg::CMD_TX_OFF])
    |=> s_q.tx_en)
    else $error("Transmit enable not taken");
  disable_cmd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_cmd && !soft_rst && wr_val[ssrc_pkg::CMD_TX_OFF]) |=> !s_q.tx_en)
    else $error("Transmit disable not taken");
  div_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_q.div == 12'h0) |=> !s_q.div_clk)
    else $error("Divider runs at zero");
  dma_size_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_q.rfm[4:0] > 5'd15) |-> dma_size == 2'h2)
    else $error("DMA size wrong");
  clk_pin_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rx_clock_output_mode == 2'h0) |-> !rx_clock_pin_oe)
    else $error("Clock pin driven in input mode");
  sync_pin_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sync_output_shape == 3'h0) |-> !rx_sync_pin_oe)
    else $error("Sync pin driven in input mode");
  edge_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!soft_rst && s_q.rf_live && !edge_sel && !s_q.rf_prev && rf_in && !s_q.wr_pend)
    |=> s_q.syn_flag)
    else $error("Rising sync edge missed");
  word_valid_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_q.valid |-> s_q.rxrdy && $past(s_q.phase) == ssrc_pkg::SSRC_DATA)
    else $error("Word completed outside data phase");
endmodule

// >>> sim/ssrc_peer.sv
// Serial peer driving the receive clock, frame sync and data pins.
// Assumes the receiver samples on the falling clock edge, inversion clear.
`timescale 1ns/1ps
module ssrc_peer (
  input wire logic clk_sys,
  output logic peer_clk,
  output logic peer_sync,
  output logic peer_data
);
  localparam int HALF = 3;
  initial begin
    peer_clk = 1'b1;
    peer_sync = 1'b1;
    peer_data = 1'b0;
  end
  // Lead bit with sync high, then n bits with sync low, index 0 first
  task automatic send(input logic [39:0] bits, input int n);
    for (int i = -1; i < n; i++) begin
      @(posedge clk_sys);
      if (i < 0) begin
        peer_data <= ~bits[0];
      end else begin
        peer_data <= bits[i];
      end
      peer_sync <= (i < 0);
      repeat (HALF) @(posedge clk_sys);
      peer_clk <= 1'b0;
      repeat (HALF) @(posedge clk_sys);
      peer_clk <= 1'b1;
    end
    @(posedge clk_sys);
    peer_sync <= 1'b1;
    peer_data <= ~peer_data;
  endtask
endmodule

// >>> sim/ssrc_top_tb.sv
// Self-checking bench for the serial receive controller top.
// Assumes ssrc_pkg, ssrc_top and the peer model ssrc_peer.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module ssrc_top_tb;
  localparam logic [31:0] RXON = 32'h1 << ssrc_pkg::CMD_RX_ON;
  localparam logic [31:0] RXOFF = 32'h1 << ssrc_pkg::CMD_RX_OFF;
  localparam logic [31:0] TXON = 32'h1 << ssrc_pkg::CMD_TX_ON;
  localparam logic [31:0] TXOFF = 32'h1 << ssrc_pkg::CMD_TX_OFF;
  localparam logic [31:0] SRST = 32'h1 << ssrc_pkg::CMD_SOFT_RST;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic rk_o;
  logic rk_oe;
  logic rs_o;
  logic rs_oe;
  logic tx_enabled;
  logic rx_word_valid;
  logic [1:0] dma_size;
  logic peer_clk;
  logic peer_sync;
  logic peer_data;
  logic loop_mode = 1'b0;
  logic tog = 1'b0;
  logic [31:0] rd;
  int error_cnt = 0;
  int checks_done = 0;
  int words = 0;
  int lens[4] = '{7, 8, 15, 16};
  logic [1:0] dsz[4] = '{2'h0, 2'h1, 2'h1, 2'h2};
  // Pin levels resolved from both parties; idle lines never hold stale data
  wire rk_w = rk_oe ? rk_o : (loop_mode ? 1'b1 : peer_clk);
  wire rs_w = rs_oe ? rs_o : (loop_mode ? 1'b1 : peer_sync);
  wire rd_w = loop_mode ? tog : peer_data;
  wire tk_w = loop_mode ? peer_clk : 1'b1;
  wire tf_w = loop_mode ? peer_sync : 1'b1;
  wire td_w = loop_mode ? peer_data : tog;

  ssrc_top u_ssrc_top (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_clock_pin_i(rk_w),
    .rx_clock_pin_o(rk_o), .rx_clock_pin_oe(rk_oe), .rx_sync_pin_i(rs_w),
    .rx_sync_pin_o(rs_o), .rx_sync_pin_oe(rs_oe), .rx_data_pin(rd_w), .tx_clock_pin(tk_w),
    .tx_sync_pin(tf_w), .tx_data_pin(td_w), .tx_start(1'b0), .tx_enabled(tx_enabled),
    .dma_size(dma_size), .rx_word_valid(rx_word_valid));
  ssrc_peer u_ssrc_peer (.clk_sys(clk_sys), .peer_clk(peer_clk), .peer_sync(peer_sync),
    .peer_data(peer_data));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    tog <= ~tog;
    if (rx_word_valid === 1'b1) begin
      words <= words + 1;
    end
  end

  task automatic results();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      results();
    end
  endtask
  // One single-word transfer; read data lands in rd
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic stat();
    xfer(1'b0, ssrc_pkg::OFF_STAT, 32'h0);
  endtask

  task automatic t_regs();
    xfer(1'b0, ssrc_pkg::OFF_CLKDIV, 32'h0);
    `CHK(rd, ssrc_pkg::RST_VAL)
    xfer(1'b0, ssrc_pkg::OFF_RXCLK, 32'h0);
    `CHK(rd, ssrc_pkg::RST_VAL)
    xfer(1'b0, ssrc_pkg::OFF_RXFRM, 32'h0);
    `CHK(rd, ssrc_pkg::RST_VAL)
    for (int i = 0; i <= 8; i++) begin
      xfer(1'b1, ssrc_pkg::OFF_RXCLK, (32'(i) << ssrc_pkg::RC_START) | 32'(i % 3));
      xfer(1'b0, ssrc_pkg::OFF_RXCLK, 32'h0);
      `CHK(rd, (32'(i) << ssrc_pkg::RC_START) | 32'(i % 3))
    end
    xfer(1'b1, 8'h08, 32'h5a5a_5a5a);
    xfer(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  task automatic t_cmd();
    xfer(1'b1, ssrc_pkg::OFF_CMD, RXON | RXOFF);
    stat();
    `CHK(rd[ssrc_pkg::ST_RECEIVE_ON_CMD], 1'b0)
    xfer(1'b1, ssrc_pkg::OFF_CMD, RXON);
    xfer(1'b1, ssrc_pkg::OFF_CMD, 32'h0);
    stat();
    `CHK(rd[ssrc_pkg::ST_RECEIVE_ON_CMD], 1'b1)
    xfer(1'b1, ssrc_pkg::OFF_CMD, TXON | TXOFF);
    stat();
    `CHK(rd[ssrc_pkg::ST_TRANSMIT_ON_CMD], 1'b0)
    xfer(1'b1, ssrc_pkg::OFF_CMD, TXON);
    stat();
    `CHK(tx_enabled, 1'b1)
    xfer(1'b1, ssrc_pkg::OFF_CMD, TXOFF);
    stat();
    `CHK(rd[ssrc_pkg::ST_TRANSMIT_ON_CMD], 1'b0)
  endtask
  task automatic t_srst();
    xfer(1'b1, ssrc_pkg::OFF_RXFRM, 32'h0000_0107);
    xfer(1'b1, ssrc_pkg::OFF_CMD, RXON | TXON);
    xfer(1'b1, ssrc_pkg::OFF_CMD, SRST | RXON | TXON);
    xfer(1'b0, ssrc_pkg::OFF_RXFRM, 32'h0);
    `CHK(rd, ssrc_pkg::RST_VAL)
    stat();
    `CHK(rd[ssrc_pkg::ST_RECEIVE_ON_CMD], 1'b0)
    `CHK(tx_enabled, 1'b0)
  endtask
  // Cycles between two rising edges of the clock (sel 0) or sync pin output, -1 if none
  task automatic rise_gap(input logic sel, output int n);
    logic p;
    int t1;
    p = sel ? rs_o : rk_o;
    t1 = -1;
    n = -1;
    for (int k = 0; k < 80 && n < 0; k++) begin
      @(posedge clk_sys);
      if (p === 1'b0 && (sel ? rs_o : rk_o) === 1'b1) begin
        if (t1 < 0) begin
          t1 = k;
        end else begin
          n = k - t1;
        end
      end
      p = sel ? rs_o : rk_o;
    end
  endtask
  task automatic t_div();
    int n;
    xfer(1'b1, ssrc_pkg::OFF_CLKDIV, 32'h3);
    xfer(1'b1, ssrc_pkg::OFF_RXCLK, 32'h1 << ssrc_pkg::RC_CKO);
    @(posedge clk_sys);
    `CHK(rk_oe, 1'b1)
    rise_gap(1'b0, n);
    `CHK(n, 6)
    xfer(1'b1, ssrc_pkg::OFF_CLKDIV, 32'h0);
    rise_gap(1'b0, n);
    `CHK(n, -1)
    xfer(1'b1, ssrc_pkg::OFF_RXCLK, 32'h0);
    @(posedge clk_sys);
    `CHK(rk_oe, 1'b0)
  endtask
  // Generated sync from the divided clock: positive pulse, then toggle shape
  task automatic t_sync();
    int n;
    int hi;
    xfer(1'b1, ssrc_pkg::OFF_CLKDIV, 32'h2);
    xfer(1'b1, ssrc_pkg::OFF_RXCLK, 32'h1 << ssrc_pkg::RC_PER);
    xfer(1'b1, ssrc_pkg::OFF_RXFRM, 32'h7 | (32'h2 << ssrc_pkg::RF_SYNC_OUTPUT_SHAPE));
    @(posedge clk_sys);
    `CHK(rs_oe, 1'b1)
    rise_gap(1'b1, n);
    `CHK(n, 16)
    hi = 0;
    repeat (32) begin
      @(posedge clk_sys);
      hi += int'(rs_o === 1'b1);
    end
    `CHK(hi, 8)
    xfer(1'b1, ssrc_pkg::OFF_RXFRM, 32'h7 | (32'h5 << ssrc_pkg::RF_SYNC_OUTPUT_SHAPE));
    rise_gap(1'b1, n);
    `CHK(n, 32)
    xfer(1'b1, ssrc_pkg::OFF_RXFRM, 32'h7);
    xfer(1'b1, ssrc_pkg::OFF_RXCLK, 32'h0);
    xfer(1'b1, ssrc_pkg::OFF_CLKDIV, 32'h0);
  endtask
  task automatic t_dma();
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, ssrc_pkg::OFF_RXFRM, 32'(lens[i]));
      @(posedge clk_sys);
      `CHK(dma_size, dsz[i])
    end
  endtask
  // Byte words from the pin peer, start on a falling sync edge
  task automatic t_frame(input logic [7:0] v, input logic high_bit_first, input int dly, input int nw,
                         input logic lp, input logic off_mid);
    logic [39:0] b;
    int w0;
    b = '0;
    for (int i = 0; i < dly; i++) begin
      b[i] = i[0];
    end
    for (int w = 0; w < nw; w++) begin
      for (int i = 0; i < 8; i++) begin
        b[dly + 8 * w + i] = (high_bit_first ? v[7 - i] : v[i]) ^ w[0];
      end
    end
    loop_mode <= lp;
    xfer(1'b1, ssrc_pkg::OFF_RXCLK, 32'h0000_0402 | (32'(dly) << ssrc_pkg::RC_DLY));
    xfer(1'b1, ssrc_pkg::OFF_RXFRM, 32'h7 | (32'(high_bit_first) << ssrc_pkg::RF_HIGH_BIT_FIRST)
         | (32'(nw - 1) << ssrc_pkg::RF_NB) | (32'(lp) << ssrc_pkg::RF_LOOP));
    xfer(1'b1, ssrc_pkg::OFF_CMD, RXON);
    w0 = words;
    fork
      u_ssrc_peer.send(b, dly + 8 * nw);
      if (off_mid) begin
        repeat (20) @(posedge clk_sys);
        xfer(1'b1, ssrc_pkg::OFF_CMD, RXOFF);
      end
    join
    repeat (4) @(posedge clk_sys);
    `CHK(words - w0, nw)
    xfer(1'b0, ssrc_pkg::OFF_RXDATA, 32'h0);
    `CHK(rd[7:0], v ^ ((nw == 2) ? 8'hff : 8'h00))
    stat();
    `CHK(rd[ssrc_pkg::ST_RX_SYNC_EDGE_FLAG], 1'b1)
    if (off_mid) begin
      stat();
      `CHK(rd[ssrc_pkg::ST_RECEIVE_ON_CMD], 1'b0)
    end
    loop_mode <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_cmd();
    t_srst();
    t_div();
    t_sync();
    t_dma();
    t_frame(8'h4d, 1'b1, 0, 1, 1'b0, 1'b0);
    t_frame(8'h4d, 1'b0, 0, 1, 1'b0, 1'b0);
    t_frame(8'hb2, 1'b1, 2, 1, 1'b0, 1'b0);
    t_frame(8'h36, 1'b0, 0, 2, 1'b0, 1'b0);
    t_frame(8'hc5, 1'b1, 0, 1, 1'b1, 1'b0);
    t_frame(8'h5e, 1'b0, 0, 1, 1'b0, 1'b1);
    results();
  end
endmodule
